// File: src/power_state_and_reset_sequencer.sv
// power-state and reset sequencer top
// ----------------------------------------------------------------
// Behaviour
// - supply enable low forces powered-down state immediately, from any state.
// - powered-down keeps sleep clock and internal supply off.
// - internal power and clock settle within 1.3 ms of enable.
// - after settling, enter firmware-load state for host download.
// - sleep only on host decision; radio and lock loop switched off.
// - sleep ends on timer expiry or host wake signal.
// - sleep keeps internal state while crystal is off.
// - wake passes warm-up: crystal first, lock loop next, then active.
// - active gates fast clock per block by clock select; radio enabled.
// - host may hold enable low for off, pulse low for reset.
// - power-on reset done within 1.3 ms; crystal clock default 26 MHz.
// - after full reset stay off, core blocks unpowered, until host talks.
// - on host start, crystal on first, lock loop afterwards.
// - block resets released automatically once every clock is stable.
// - module sleep requests gate per-module clock enable and power.
// - no start under low supply lockout; lockout turns device off.
// ----------------------------------------------------------------
`default_nettype none
module power_state_and_reset_sequencer #(
	parameter int NUM_MODULES   = pwr_seq_pkg::NUM_MODULES,
	parameter int SETTLE_CYCLES = pwr_seq_pkg::SETTLE_CYCLES,
	parameter int LOCK_CYCLES   = pwr_seq_pkg::LOCK_CYCLES,
	parameter int XTAL_CYCLES   = pwr_seq_pkg::XTAL_CYCLES
) (
	input  wire logic                        mclk_i,
	input  wire logic                        reset_n_i,
	input  wire logic                        supply_enable_pin_i,
	input  wire logic                        wake_pin_i,
	input  wire logic                        low_supply_lockout_i,
	input  wire logic                        host_start_i,
	input  wire logic                        host_sleep_req_i,
	input  wire logic                        host_go_active_i,
	input  wire logic [pwr_seq_pkg::TIMER_W-1:0] sleep_duration_i,
	input  wire logic [NUM_MODULES-1:0]      clk_select_i,
	input  wire logic [NUM_MODULES-1:0]      module_sleep_req_i,
	output logic                             internal_supply_on_o,
	output logic                             sleep_clock_on_o,
	output logic                             xtal_enable_o,
	output logic                             digital_lock_loop_enable_o,
	output logic                             radio_enable_o,
	output logic                             core_power_on_o,
	output logic                             core_reset_n_o,
	output logic [NUM_MODULES-1:0]           module_clk_en_o,
	output logic [NUM_MODULES-1:0]           module_power_o,
	output logic [2:0]                       power_state_o
);
	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	logic [2:0] sync_in;
	logic       enable_s;
	logic       wake_s;
	logic       lockout_s;
	logic       off_rst_n;

	level_sync #(.WIDTH(3)) u_sync (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   ({supply_enable_pin_i, wake_pin_i, low_supply_lockout_i}),
		.sync_o    (sync_in)
	);
	assign enable_s  = sync_in[2];
	assign wake_s    = sync_in[1];
	assign lockout_s = sync_in[0];

	// asynchronous forced entry to off, a raw pin low is acted on at once
	assign off_rst_n = reset_n_i & supply_enable_pin_i;

	// ----------------------------------------------------------------
	// state and timers
	// ----------------------------------------------------------------
	pwr_seq_pkg::power_state_type state;
	pwr_seq_pkg::power_state_type next_state;
	pwr_seq_pkg::warm_phase_type  phase;
	pwr_seq_pkg::warm_phase_type  next_phase;
	logic [31:0]                  timer;
	logic [31:0]                  next_timer;
	logic [pwr_seq_pkg::TIMER_W-1:0] sleep_left;
	logic                         settled;
	logic                         started;
	logic                         next_started;
	logic                         timer_done;
	logic                         sleep_expired;
	logic                         go_off;
	logic                         wake_event;
	logic                         clocks_stable;

	assign timer_done    = (timer == 32'h0);
	assign sleep_expired = (sleep_left == '0);
	assign go_off        = !enable_s || lockout_s;
	assign wake_event    = wake_s || sleep_expired;
	// sleep and warm-up keep block resets released, else retained state would be lost
	assign clocks_stable = (state == pwr_seq_pkg::ACTIVE)
		|| (state == pwr_seq_pkg::SLEEP) || (state == pwr_seq_pkg::WARM_UP)
		|| (state == pwr_seq_pkg::FIRMWARE_LOAD && started && phase == pwr_seq_pkg::WARM_DONE);

	always_comb begin
		next_state   = state;
		next_phase   = phase;
		next_timer   = timer_done ? 32'h0 : timer - 32'h1;
		next_started = started;
		unique case (state)
			pwr_seq_pkg::POWERED_OFF: begin
				next_started = 1'b0;
				if (!go_off && !settled) begin
					next_timer = 32'(SETTLE_CYCLES);
				end
				if (!go_off && settled && timer_done) begin
					next_state = pwr_seq_pkg::FIRMWARE_LOAD;
				end
			end
			pwr_seq_pkg::FIRMWARE_LOAD: begin
				// core waits unpowered until host talks
				if (host_start_i && !started) begin
					next_started = 1'b1;
					next_phase   = pwr_seq_pkg::WARM_XTAL;
					next_timer   = 32'(XTAL_CYCLES);
				end else if (started && timer_done && phase == pwr_seq_pkg::WARM_XTAL) begin
					next_phase = pwr_seq_pkg::WARM_LOCK;
					next_timer = 32'(LOCK_CYCLES);
				end else if (started && timer_done && phase == pwr_seq_pkg::WARM_LOCK) begin
					next_phase = pwr_seq_pkg::WARM_DONE;
				end else if (phase == pwr_seq_pkg::WARM_DONE && started && host_go_active_i) begin
					next_state = pwr_seq_pkg::ACTIVE;
				end
			end
			pwr_seq_pkg::ACTIVE: begin
				if (host_sleep_req_i) begin
					next_state = pwr_seq_pkg::SLEEP;
				end
			end
			pwr_seq_pkg::SLEEP: begin
				if (wake_event) begin
					next_state = pwr_seq_pkg::WARM_UP;
					next_phase = pwr_seq_pkg::WARM_XTAL;
					next_timer = 32'(XTAL_CYCLES);
				end
			end
			pwr_seq_pkg::WARM_UP: begin
				if (timer_done && phase == pwr_seq_pkg::WARM_XTAL) begin
					next_phase = pwr_seq_pkg::WARM_LOCK;
					next_timer = 32'(LOCK_CYCLES);
				end else if (timer_done && phase == pwr_seq_pkg::WARM_LOCK) begin
					next_phase = pwr_seq_pkg::WARM_DONE;
					next_state = pwr_seq_pkg::ACTIVE;
				end
			end
			default: begin
				next_state = pwr_seq_pkg::POWERED_OFF;
			end
		endcase
		if (go_off) begin
			next_state   = pwr_seq_pkg::POWERED_OFF;
			next_started = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge off_rst_n) begin
		if (!off_rst_n) begin
			state   <= pwr_seq_pkg::POWERED_OFF;
			phase   <= pwr_seq_pkg::WARM_XTAL;
			timer   <= 32'h0;
			settled <= 1'b0;
			started <= 1'b0;
		end else begin
			state   <= next_state;
			phase   <= next_phase;
			timer   <= next_timer;
			started <= next_started;
			settled <= (state == pwr_seq_pkg::POWERED_OFF) && !go_off;
		end
	end

	// sleep timer loads on entry, state held while the crystal is off
	always_ff @(posedge mclk_i or negedge off_rst_n) begin
		if (!off_rst_n) begin
			sleep_left <= '1;
		end else if (state != pwr_seq_pkg::SLEEP) begin
			sleep_left <= sleep_duration_i;
		end else if (!sleep_expired) begin
			sleep_left <= sleep_left - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic in_off;
	logic xtal_on;
	logic lock_on;
	logic release_req;
	logic block_rst_n;

	assign in_off  = (state == pwr_seq_pkg::POWERED_OFF);
	assign xtal_on = (state == pwr_seq_pkg::ACTIVE)
		|| ((state == pwr_seq_pkg::WARM_UP || state == pwr_seq_pkg::FIRMWARE_LOAD) && started)
		|| (state == pwr_seq_pkg::WARM_UP);
	assign lock_on = (state == pwr_seq_pkg::ACTIVE)
		|| ((state == pwr_seq_pkg::WARM_UP || state == pwr_seq_pkg::FIRMWARE_LOAD)
			&& phase != pwr_seq_pkg::WARM_XTAL && (started || state == pwr_seq_pkg::WARM_UP));
	assign release_req = clocks_stable && !in_off;

	reset_release u_rel (
		.mclk_i          (mclk_i),
		.reset_n_i       (off_rst_n),
		.release_i       (release_req),
		.block_reset_n_o (block_rst_n)
	);

	always_ff @(posedge mclk_i or negedge off_rst_n) begin
		if (!off_rst_n) begin
			internal_supply_on_o       <= 1'b0;
			sleep_clock_on_o           <= 1'b0;
			xtal_enable_o              <= 1'b0;
			digital_lock_loop_enable_o <= 1'b0;
			radio_enable_o             <= 1'b0;
			core_power_on_o            <= 1'b0;
			module_clk_en_o            <= '0;
			module_power_o             <= '0;
			power_state_o              <= 3'h0;
		end else begin
			internal_supply_on_o       <= !in_off;
			sleep_clock_on_o           <= !in_off;
			xtal_enable_o              <= xtal_on;
			digital_lock_loop_enable_o <= lock_on;
			radio_enable_o             <= (state == pwr_seq_pkg::ACTIVE);
			core_power_on_o            <= !in_off && (started || state != pwr_seq_pkg::FIRMWARE_LOAD);
			module_clk_en_o            <= (state == pwr_seq_pkg::ACTIVE)
				? (clk_select_i & ~module_sleep_req_i) : '0;
			module_power_o             <= (in_off || !started && state == pwr_seq_pkg::FIRMWARE_LOAD)
				? '0 : ~module_sleep_req_i;
			power_state_o              <= 3'(state);
		end
	end
	assign core_reset_n_o = block_rst_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	off_supply_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		in_off |=> !internal_supply_on_o) else $error("supply on while off");
	lockout_off_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		lockout_s |=> in_off) else $error("lockout did not turn off");
	sleep_radio_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		(state == pwr_seq_pkg::SLEEP) |=> !radio_enable_o) else $error("radio on in sleep");
	sleep_entry_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		($past(state) == pwr_seq_pkg::ACTIVE && state == pwr_seq_pkg::SLEEP) |-> $past(host_sleep_req_i))
		else $error("sleep without host");
	wake_exit_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		(state == pwr_seq_pkg::SLEEP && wake_s && enable_s && !lockout_s) |=> state == pwr_seq_pkg::WARM_UP)
		else $error("wake ignored");
	warm_order_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		digital_lock_loop_enable_o |-> xtal_enable_o) else $error("lock loop before crystal");
	reset_hold_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		in_off |=> !core_reset_n_o) else $error("reset released while off");
	gate_clock_a : assert property (@(posedge mclk_i) disable iff (!off_rst_n)
		(state == pwr_seq_pkg::ACTIVE && state == $past(state)) |-> ##1
		(module_clk_en_o & $past(module_sleep_req_i)) == '0) else $error("sleeping module clocked");
endmodule : power_state_and_reset_sequencer
`default_nettype wire

// File: src/pwr_seq_pkg.sv
// constants and types for the power-state and reset sequencer
`default_nettype none
package pwr_seq_pkg;
	localparam int  CLK_HZ           = 40000000;
	localparam real SETTLE_MS        = 1.3;
	localparam int  SETTLE_CYCLES    = int'(SETTLE_MS * 1.0e-3 * CLK_HZ);
	localparam real XTAL_START_US    = 10.0;
	localparam int  XTAL_CYCLES      = int'(XTAL_START_US * 1.0e-6 * CLK_HZ);
	localparam real LOCK_START_US    = 100.0;
	localparam int  LOCK_CYCLES      = int'(LOCK_START_US * 1.0e-6 * CLK_HZ);
	localparam int  XTAL_DEFAULT_MHZ = 26;
	localparam int  NUM_MODULES      = 4;
	localparam int  SYNC_STAGES      = 2;
	localparam int  TIMER_W          = 32;
	localparam logic [NUM_MODULES-1:0] CLK_SEL_RESET = 4'hf;

	typedef enum logic [2:0] {
		POWERED_OFF,
		FIRMWARE_LOAD,
		WARM_UP,
		ACTIVE,
		SLEEP
	} power_state_type;

	typedef enum logic [1:0] {
		WARM_XTAL,
		WARM_LOCK,
		WARM_DONE
	} warm_phase_type;
endpackage : pwr_seq_pkg
`default_nettype wire

// File: src/level_sync.sv
// two-stage synchroniser for asynchronous level inputs
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	// stage1 feeds only the second flop
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage1 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule : level_sync
`default_nettype wire

// File: src/reset_release.sv
// reset bridge: asynchronous assert, synchronous release
`default_nettype none
module reset_release (
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	input  wire logic release_i,
	output logic      block_reset_n_o
);
	logic stage1;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage1          <= 1'b0;
			block_reset_n_o <= 1'b0;
		end else begin
			stage1          <= release_i;
			block_reset_n_o <= stage1 & release_i;
		end
	end
endmodule : reset_release
`default_nettype wire

// File: testbench/host_model.sv
// host controller model: drives enable, wake and the host requests
`default_nettype none
module host_model #(
	parameter int LOCK_CYCLES = 8
) (
	input  wire logic mclk_i,
	output var  logic supply_enable_pin_o,
	output var  logic wake_pin_o,
	output var  logic host_start_o,
	output var  logic host_sleep_req_o,
	output var  logic host_go_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		supply_enable_pin_o = 1'b0;
		wake_pin_o          = 1'b0;
		host_start_o        = 1'b0;
		host_sleep_req_o    = 1'b0;
		host_go_active_o    = 1'b0;
	end
	// hold low turns off, a short low pulse resets
	task automatic set_enable(input logic v);
		@(posedge mclk_i);
		supply_enable_pin_o <= v;
	endtask : set_enable
	task automatic set_wake(input logic v);
		@(posedge mclk_i);
		wake_pin_o <= v;
	endtask : set_wake
	task automatic start_comm();
		@(posedge mclk_i);
		host_start_o <= 1'b1;
		@(posedge mclk_i);
		host_start_o <= 1'b0;
	endtask : start_comm
	// lock loop must settle before full-speed switch
	task automatic go_active();
		repeat (LOCK_CYCLES) @(posedge mclk_i);
		host_go_active_o <= 1'b1;
		@(posedge mclk_i);
		host_go_active_o <= 1'b0;
	endtask : go_active
	// sleep entry is only ever a host decision
	task automatic ask_sleep();
		@(posedge mclk_i);
		host_sleep_req_o <= 1'b1;
		@(posedge mclk_i);
		host_sleep_req_o <= 1'b0;
	endtask : ask_sleep
endmodule : host_model
`default_nettype wire

// File: testbench/test_power_state_and_reset_sequencer.sv
// self-checking bench for the power-state and reset sequencer
`default_nettype none
module test_power_state_and_reset_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 20;
	localparam int LOCK   = 8;
	localparam int XTAL   = 4;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic lockout = 1'b0;
	logic [31:0] duration = 32'h0000001e;
	logic [3:0] clk_sel = 4'hf;
	logic [3:0] mod_sleep = 4'h0;
	wire  en_pin, wake, start, sleep_req, go_act;
	wire  supply_on, sleep_clk, xtal, lock_en, radio, core_pwr, core_rst_n;
	wire  [3:0] clk_en;
	wire  [3:0] mod_pwr;
	wire  [2:0] state;
	wire  [3:0] mon = {xtal, lock_en, core_rst_n, radio};
	int   miscompares = 0;
	int   checks = 0;
	always #12.5 mclk_i = ~mclk_i;
	host_model #(.LOCK_CYCLES(LOCK)) host_u (.mclk_i(mclk_i), .supply_enable_pin_o(en_pin),
		.wake_pin_o(wake), .host_start_o(start), .host_sleep_req_o(sleep_req), .host_go_active_o(go_act));
	power_state_and_reset_sequencer #(.SETTLE_CYCLES(SETTLE), .LOCK_CYCLES(LOCK), .XTAL_CYCLES(XTAL)) dut_u (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .supply_enable_pin_i(en_pin), .wake_pin_i(wake),
		.low_supply_lockout_i(lockout), .host_start_i(start), .host_sleep_req_i(sleep_req),
		.host_go_active_i(go_act), .sleep_duration_i(duration), .clk_select_i(clk_sel),
		.module_sleep_req_i(mod_sleep), .internal_supply_on_o(supply_on), .sleep_clock_on_o(sleep_clk),
		.xtal_enable_o(xtal), .digital_lock_loop_enable_o(lock_en), .radio_enable_o(radio),
		.core_power_on_o(core_pwr), .core_reset_n_o(core_rst_n), .module_clk_en_o(clk_en),
		.module_power_o(mod_pwr), .power_state_o(state));
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// bounded waits; running out counts as a mismatch
	task automatic wait_state(input logic [2:0] s, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_i);
			#1;
			if (state === s) return;
		end
		check("state wait", {29'h0, state}, {29'h0, s});
		finish_test();
	endtask : wait_state
	task automatic wait_bit(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_i);
			#1;
			if (mon[idx] === 1'b1) return;
		end
		check("signal wait", {31'h0, mon[idx]}, 32'h1);
		finish_test();
	endtask : wait_bit
	task automatic t_lockout_start();
		lockout <= 1'b1;
		host_u.set_enable(1'b1);
		repeat (SETTLE + 20) @(posedge mclk_i);
		#1 check("state", state, 32'h0);
		lockout <= 1'b0;
		wait_state(3'h1, SETTLE + 10);
		check("supply", {sleep_clk, supply_on}, 32'h3);
		check("core", {core_pwr, core_rst_n, xtal}, 32'h0);
		lockout <= 1'b1;
		wait_state(3'h0, 8);
		lockout <= 1'b0;
		wait_state(3'h1, SETTLE + 10);
	endtask : t_lockout_start
	task automatic t_bring_up();
		host_u.start_comm();
		wait_bit(3, XTAL + 6);
		check("lock early", lock_en, 32'h0);
		wait_bit(2, XTAL + 6);
		wait_bit(1, LOCK + 10);
		host_u.go_active();
		wait_state(3'h3, 8);
		#50 check("radio", radio, 32'h1);
		clk_sel <= 4'h3;
		repeat (4) @(posedge mclk_i);
		#1 check("clk_en", clk_en, 32'h3);
		clk_sel <= 4'hf;
		mod_sleep <= 4'h5;
		repeat (4) @(posedge mclk_i);
		#1 check("clk_en gated", clk_en, 32'ha);
		check("module power", mod_pwr, 32'ha);
		mod_sleep <= 4'h0;
	endtask : t_bring_up
	task automatic t_sleep(input logic by_wake);
		duration <= by_wake ? 32'h0000ffff : 32'h0000001e;
		host_u.ask_sleep();
		wait_state(3'h4, 6);
		#50 check("off in sleep", {xtal, lock_en, radio}, 32'h0);
		check("kept", core_rst_n, 32'h1);
		if (by_wake) begin
			host_u.set_wake(1'b1);
			wait_state(3'h2, 6);
			host_u.set_wake(1'b0);
		end else begin
			wait_state(3'h2, 45);
		end
		wait_bit(3, XTAL + 6);
		check("warm lock", lock_en, 32'h0);
		wait_state(3'h3, XTAL + LOCK + 12);
	endtask : t_sleep
	task automatic t_pulse_off();
		host_u.set_enable(1'b0);
		#3 check("forced off", state, 32'h0);
		check("off outs", {supply_on, sleep_clk, radio}, 32'h0);
		host_u.set_enable(1'b1);
		wait_state(3'h1, SETTLE + 10);
		check("held", {core_rst_n, xtal}, 32'h0);
	endtask : t_pulse_off
	initial begin
		repeat (20) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		#1 check("reset state", state, 32'h0);
		t_lockout_start();
		t_bring_up();
		t_sleep(1'b0);
		t_sleep(1'b1);
		t_pulse_off();
		finish_test();
	end
endmodule : test_power_state_and_reset_sequencer
`default_nettype wire
